// ---- logic/motion_core_pkg.sv ----
// Purpose: Shared constants and types of the stepper motion core
// Assumes: 100 MHz mclk, one profile tick every 250 ns
// Notes:   Speeds are held internally in units of 2^-40 step per tick
package motion_core_pkg;

  // Clock and timing
  localparam int unsigned MCLK_HZ        = 100_000_000;
  localparam int unsigned TICK_NS        = 250;
  localparam int unsigned TICK_CYCLES    = TICK_NS * (MCLK_HZ / 1_000_000) / 1000;
  localparam int unsigned OSC_OUT_HZ     = 2_000_000;
  localparam int unsigned OSC_HALF_CYC   = MCLK_HZ / (2 * OSC_OUT_HZ);

  // Field widths and scaling shifts into the 2^-40 speed unit
  localparam int unsigned POS_W          = 22;
  localparam int unsigned SPEED_W        = 32;
  localparam int unsigned FRAC_W         = 40;
  localparam int unsigned MIN_SHIFT      = 16;
  localparam int unsigned MAX_SHIFT      = 22;
  localparam int unsigned RUN_SHIFT      = 12;
  localparam int unsigned DECEL_SHIFT    = 41;
  localparam int unsigned MAX_STEP_SEL   = 4;

  // Power-up default configuration
  localparam logic [11:0] ACCEL_RST      = 12'h08a;
  localparam logic [11:0] DECEL_RST      = 12'h08a;
  localparam logic [9:0]  MAX_SPEED_RST  = 10'h041;
  localparam logic [11:0] MIN_SPEED_RST  = 12'h000;
  localparam logic [9:0]  FS_SPEED_RST   = 10'h027;
  localparam logic [2:0]  STEP_SEL_RST   = 3'h4;
  localparam logic [11:0] ACCEL_INFINITE = 12'hfff;

  // Motion commands
  typedef enum logic [3:0] {
    CMD_NOP           = 4'h0,
    CMD_RUN           = 4'h1,
    CMD_ABS_TARGET    = 4'h2,
    CMD_DIR_TARGET    = 4'h3,
    CMD_MOVE          = 4'h4,
    CMD_DECEL_STOP    = 4'h5,
    CMD_IMM_STOP      = 4'h6,
    CMD_DECEL_RELEASE = 4'h7,
    CMD_IMM_RELEASE   = 4'h8
  } cmd_t;

  // Motion states
  typedef enum logic [2:0] {
    ST_HIZ  = 3'b000,
    ST_HOLD = 3'b001,
    ST_RUN  = 3'b010,
    ST_POS  = 3'b011,
    ST_STOP = 3'b100
  } state_t;

  // Whole state of the core
  typedef struct packed {
    logic [2:0]         sync1;
    logic [2:0]         sync2;
    state_t             state;
    logic               dir;
    logic               release_hiz;
    logic [11:0]        accel;
    logic [11:0]        decel;
    logic [9:0]         max_speed;
    logic [11:0]        min_speed;
    logic [9:0]         fs_speed;
    logic [2:0]         step_sel;
    logic [SPEED_W-1:0] speed;
    logic [SPEED_W-1:0] target;
    logic [FRAC_W-1:0]  frac;
    logic [POS_W-1:0]   pos;
    logic [POS_W-1:0]   remain;
    logic [5:0]         elec;
    logic               pos_valid;
    logic [4:0]         tick_cnt;
    logic [4:0]         osc_cnt;
    logic               osc;
    logic               undervoltage_lockout_bit_bit;
    logic               step_pulse;
    logic               fullstep;
  } core_t;

  localparam core_t CORE_RST = '{
    sync1: 3'h0, sync2: 3'h0, state: ST_HIZ, dir: 1'b0, release_hiz: 1'b0,
    accel: ACCEL_RST, decel: DECEL_RST, max_speed: MAX_SPEED_RST,
    min_speed: MIN_SPEED_RST, fs_speed: FS_SPEED_RST, step_sel: STEP_SEL_RST,
    speed: 32'h0, target: 32'h0, frac: 40'h0, pos: 22'h0, remain: 22'h0,
    elec: 6'h0, pos_valid: 1'b1, tick_cnt: 5'h0, osc_cnt: 5'h0, osc: 1'b0,
    undervoltage_lockout_bit_bit: 1'b0, step_pulse: 1'b0, fullstep: 1'b0
  };

endpackage

// ---- logic/stepper_motion_profile_core.sv ----
// Purpose: Motion core of a microstepping stepper driver
// Assumes: Commands and configuration come from same-clock logic
// Notes:   Power-good and oscillator-good pins are synchronised first
`timescale 1ns/10ps

module stepper_motion_profile_core (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Power and oscillator status pins
  input  wire logic        supply_ok,
  input  wire logic        osc_ok,
  input  wire logic        motor_supply_ok,
  // Configuration load
  input  wire logic        cfg_write,
  input  wire logic [11:0] accel_rate,
  input  wire logic [11:0] decel_rate,
  input  wire logic [9:0]  max_speed,
  input  wire logic [11:0] min_speed,
  input  wire logic [9:0]  fullstep_threshold_speed,
  input  wire logic [2:0]  step_sel,
  // Command port
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_code,
  input  wire logic        cmd_dir,
  input  wire logic [19:0] cmd_speed,
  input  wire logic [21:0] cmd_position,
  output logic             cmd_ready,
  // Status
  input  wire logic        status_clear,
  output logic             undervoltage_lockout_bit,
  output logic [21:0]      absolute_position,
  output logic             position_valid,
  output logic [31:0]      current_speed,
  output logic [2:0]       motor_state,
  // Bridge drive
  output logic             bridges_enable,
  output logic             fullstep_mode,
  output logic [5:0]       electrical_position,
  output logic             step_pulse,
  output logic             step_dir,
  // Open-drain and clock pins
  output logic             busy_o,
  output logic             busy_oe_n,
  output logic             flag_o,
  output logic             flag_oe_n,
  output logic             oscillator_output_pin
);

  motion_core_pkg::core_t s_q;
  motion_core_pkg::core_t s_d;

  // Deceleration distance check: v^2 * 2^sel >= 2 * d * remaining * 2^40
  function automatic logic decel_due(input logic [31:0] v, input logic [11:0] d,
                                     input logic [21:0] r, input logic [2:0] sel);
    logic [79:0] lhs;
    logic [79:0] rhs;
    lhs = 80'({48'h0, v} * {48'h0, v}) << sel;
    rhs = 80'({68'h0, d} * {58'h0, r}) << motion_core_pkg::DECEL_SHIFT;
    return lhs >= rhs;
  endfunction

  // Clamp resolution code to the finest supported microstep
  function automatic logic [2:0] sel_clamp(input logic [2:0] sel);
    return (sel > 3'(motion_core_pkg::MAX_STEP_SEL)) ?
           3'(motion_core_pkg::MAX_STEP_SEL) : sel;
  endfunction

  logic live;
  logic uv_fail;
  logic moving;
  logic tick;
  logic infinite;
  logic [2:0]  sel;
  logic [2:0]  acc_shift;
  logic [21:0] pos_inc;
  logic [5:0]  elec_inc;
  logic [31:0] min_v;
  logic [31:0] max_v;
  logic [31:0] run_v;
  logic [31:0] goal;
  logic [32:0] up;
  logic [32:0] down;
  logic [40:0] sum;
  logic [21:0] diff;

  // Live once the supply-good and oscillator-good pins are seen through two flops
  assign live      = s_q.sync2[2] & s_q.sync2[1];
  assign uv_fail   = ~s_q.sync2[0];
  assign moving    = (s_q.state == motion_core_pkg::ST_RUN) ||
                     (s_q.state == motion_core_pkg::ST_POS) ||
                     (s_q.state == motion_core_pkg::ST_STOP);
  assign cmd_ready = live;

  // Speed limits scaled into the common 2^-40 unit
  assign min_v = {4'h0, s_q.min_speed, 16'h0};
  assign max_v = {s_q.max_speed, 22'h0};
  assign run_v = {cmd_speed, 12'h0};
  assign infinite = (s_q.accel == motion_core_pkg::ACCEL_INFINITE);

  // Step size depends on resolution and full-step override
  assign sel       = sel_clamp(s_q.step_sel);
  assign acc_shift = s_q.fullstep ? 3'h0 : sel;
  assign pos_inc   = s_q.fullstep ? (22'h1 << sel) : 22'h1;
  assign elec_inc  = s_q.fullstep ? 6'h10 : (6'h10 >> sel);
  assign tick      = (s_q.tick_cnt == 5'(motion_core_pkg::TICK_CYCLES - 1));

  // Speed goal of the current profile phase
  always_comb begin
    case (s_q.state)
      motion_core_pkg::ST_RUN:  goal = s_q.target;
      motion_core_pkg::ST_POS:  goal = (!infinite &&
                                        decel_due(s_q.speed, s_q.decel, s_q.remain, sel))
                                       ? min_v : max_v;
      motion_core_pkg::ST_STOP: goal = min_v;
      default:                  goal = 32'h0;
    endcase
  end

  // Ramped speeds one rate step up or down
  assign up   = {1'b0, s_q.speed} + {21'h0, s_q.accel};
  assign down = {1'b0, s_q.speed} - {21'h0, s_q.decel};
  assign sum  = {1'b0, s_q.frac} + (41'(s_q.speed) << acc_shift);
  assign diff = cmd_position - s_q.pos;

  // Next state of the whole core
  always_comb begin
    s_d = s_q;
    s_d.step_pulse = 1'b0;
    s_d.sync1 = {supply_ok, osc_ok, motor_supply_ok};
    s_d.sync2 = s_q.sync1;
    if (!live) begin
      // Held in reset with defaults until main supply and oscillator good
      s_d = motion_core_pkg::CORE_RST;
      s_d.sync1 = {supply_ok, osc_ok, motor_supply_ok};
      s_d.sync2 = s_q.sync1;
    end else begin
      // 2 MHz clock out from the running oscillator
      if (s_q.osc_cnt == 5'(motion_core_pkg::OSC_HALF_CYC - 1)) begin
        s_d.osc_cnt = 5'h0;
        s_d.osc     = ~s_q.osc;
      end else begin
        s_d.osc_cnt = s_q.osc_cnt + 5'h1;
      end
      s_d.tick_cnt = tick ? 5'h0 : s_q.tick_cnt + 5'h1;

      // Undervoltage bit low on fail, released by status clear
      if (uv_fail) begin
        s_d.undervoltage_lockout_bit_bit = 1'b0;
      end else if (status_clear) begin
        s_d.undervoltage_lockout_bit_bit = 1'b1;
      end

      // Configuration load; resolution change resets phase
      if (cfg_write) begin
        s_d.accel     = accel_rate;
        s_d.decel     = decel_rate;
        s_d.max_speed = max_speed;
        s_d.min_speed = min_speed;
        s_d.fs_speed  = fullstep_threshold_speed;
        s_d.step_sel  = step_sel;
        if (step_sel != s_q.step_sel) begin
          s_d.elec      = 6'h0;
          s_d.pos_valid = 1'b0;
        end
      end

      // Profile tick: ramp speed, accumulate, emit steps
      if (tick && moving) begin
        if (infinite || s_q.speed == goal) begin
          s_d.speed = goal;
        end else if (s_q.speed < goal) begin
          s_d.speed = (up[31:0] > goal || up[32]) ? goal : up[31:0];
        end else begin
          s_d.speed = (down[31:0] < goal || down[32]) ? goal : down[31:0];
        end
        s_d.fullstep = (s_d.speed > {s_q.fs_speed, 22'h0});
        s_d.frac     = sum[39:0];
        if (sum[40]) begin
          s_d.step_pulse = 1'b1;
          s_d.pos  = s_q.dir ? s_q.pos + pos_inc : s_q.pos - pos_inc;
          s_d.elec = s_q.dir ? s_q.elec + elec_inc : s_q.elec - elec_inc;
          s_d.remain = (s_q.remain > pos_inc) ? s_q.remain - pos_inc : 22'h0;
        end
        // Phase ends
        if (s_q.state == motion_core_pkg::ST_POS && s_d.remain == 22'h0) begin
          s_d.state = motion_core_pkg::ST_HOLD;
          s_d.speed = 32'h0;
        end else if (s_q.state == motion_core_pkg::ST_STOP && s_d.speed <= min_v) begin
          s_d.state = s_q.release_hiz ? motion_core_pkg::ST_HIZ
                                      : motion_core_pkg::ST_HOLD;
          s_d.speed = 32'h0;
        end
      end
      if (!moving) begin
        s_d.fullstep = 1'b0;
      end

      // Command decode; run and positioning commands are ignored while the motor supply has failed
      if (cmd_valid) begin
        case (motion_core_pkg::cmd_t'(cmd_code))
          motion_core_pkg::CMD_RUN: begin
            if (!uv_fail) begin
              s_d.state  = motion_core_pkg::ST_RUN;
              s_d.dir    = cmd_dir;
              s_d.target = (run_v > max_v) ? max_v : run_v;
              if (!moving) begin
                s_d.speed = min_v;
                s_d.frac  = 40'h0;
              end
            end
          end
          motion_core_pkg::CMD_ABS_TARGET, motion_core_pkg::CMD_DIR_TARGET,
          motion_core_pkg::CMD_MOVE: begin
            if (!uv_fail) begin
              s_d.state = motion_core_pkg::ST_POS;
              if (cmd_code == motion_core_pkg::CMD_MOVE) begin
                s_d.dir    = cmd_dir;
                s_d.remain = cmd_position;
              end else if (cmd_code == motion_core_pkg::CMD_DIR_TARGET) begin
                s_d.dir    = cmd_dir;
                s_d.remain = cmd_dir ? diff : 22'h0 - diff;
              end else begin
                s_d.dir    = ~diff[21];
                s_d.remain = diff[21] ? 22'h0 - diff : diff;
              end
              if (!moving) begin
                s_d.speed = min_v;
                s_d.frac  = 40'h0;
              end
            end
          end
          motion_core_pkg::CMD_DECEL_STOP, motion_core_pkg::CMD_DECEL_RELEASE: begin
            s_d.release_hiz = (cmd_code == motion_core_pkg::CMD_DECEL_RELEASE);
            if (moving) begin
              s_d.state = motion_core_pkg::ST_STOP;
            end else begin
              s_d.state = s_d.release_hiz ? motion_core_pkg::ST_HIZ
                                          : motion_core_pkg::ST_HOLD;
            end
          end
          motion_core_pkg::CMD_IMM_STOP: begin
            s_d.state = motion_core_pkg::ST_HOLD;
            s_d.speed = 32'h0;
          end
          motion_core_pkg::CMD_IMM_RELEASE: begin
            s_d.state = motion_core_pkg::ST_HIZ;
            s_d.speed = 32'h0;
          end
          default: begin
            s_d.state = s_d.state;
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= motion_core_pkg::CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from the state register
  assign undervoltage_lockout_bit = s_q.undervoltage_lockout_bit_bit;
  assign absolute_position        = s_q.pos;
  assign position_valid           = s_q.pos_valid;
  assign current_speed            = s_q.speed;
  assign motor_state              = s_q.state;
  assign bridges_enable           = live & (s_q.state != motion_core_pkg::ST_HIZ);
  assign fullstep_mode            = s_q.fullstep;
  assign electrical_position      = s_q.elec;
  assign step_pulse               = s_q.step_pulse;
  assign step_dir                 = s_q.dir;
  assign oscillator_output_pin    = live & s_q.osc;

  // Open-drain pins: busy while moving, alarm while undervoltage bit low
  assign busy_o    = 1'b0;
  assign busy_oe_n = ~(live & moving);
  assign flag_o    = 1'b0;
  assign flag_oe_n = ~(live & ~s_q.undervoltage_lockout_bit_bit);

endmodule

// ---- verif/motion_core_assertions.sv ----
// Purpose: Port-level checks of the stepper motion core
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Shadows follow the last accepted configuration write
`timescale 1ns/10ps

module motion_core_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Configuration and commands
  input wire logic        cfg_write,
  input wire logic [11:0] min_speed,
  input wire logic [2:0]  step_sel,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_code,
  input wire logic        cmd_ready,
  // Status and drive
  input wire logic        undervoltage_lockout_bit,
  input wire logic [21:0] absolute_position,
  input wire logic        position_valid,
  input wire logic [31:0] current_speed,
  input wire logic [2:0]  motor_state,
  input wire logic        bridges_enable,
  input wire logic        fullstep_mode,
  input wire logic [5:0]  electrical_position,
  input wire logic        step_pulse,
  input wire logic        step_dir,
  input wire logic        busy_oe_n,
  input wire logic        flag_oe_n,
  input wire logic        oscillator_output_pin
);
  logic [11:0] min_q;
  logic [2:0]  sel_q;
  logic [4:0]  osc_cnt_q;
  logic        osc_prev_q;
  logic        seen_q;
  wire  [2:0]  sel_new = (step_sel > 3'h4) ? 3'h4 : step_sel;
  wire         osc_chg = oscillator_output_pin != osc_prev_q;
  wire         take = cmd_valid && cmd_ready;

  // Shadow config and time since the last oscillator edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      min_q      <= motion_core_pkg::MIN_SPEED_RST;
      sel_q      <= motion_core_pkg::STEP_SEL_RST;
      osc_cnt_q  <= 5'h00;
      osc_prev_q <= 1'b0;
      seen_q     <= 1'b0;
    end else begin
      if (cfg_write && cmd_ready) begin
        min_q <= min_speed;
        sel_q <= sel_new;
      end
      osc_prev_q <= oscillator_output_pin;
      osc_cnt_q  <= (!cmd_ready || osc_chg) ? 5'h00 : osc_cnt_q + 5'h01;
      seen_q     <= cmd_ready && (seen_q || osc_chg);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence run_taken;
    take && cmd_code == 4'h1 && undervoltage_lockout_bit && motor_state inside {3'h0, 3'h1};
  endsequence
  sequence stop_taken;
    take && cmd_code == 4'h6;
  endsequence
  sequence hold_still;
    motor_state == 3'h1 && current_speed == 32'h0 && bridges_enable;
  endsequence

  chk_held_quiet: assert property (!cmd_ready |->
    !bridges_enable && busy_oe_n && flag_oe_n && !oscillator_output_pin)
    else $error("outputs active while core is held");
  chk_alarm_low: assert property ($rose(cmd_ready) |->
    !undervoltage_lockout_bit && !flag_oe_n) else $error("alarm not low at start");
  chk_busy_level: assert property (cmd_ready |->
    busy_oe_n == !(motor_state inside {3'h2, 3'h3, 3'h4})) else $error("busy pin wrong");
  chk_run_start: assert property (run_taken |=>
    bridges_enable && motor_state == 3'h2 && current_speed == {4'h0, min_q, 16'h0})
    else $error("run did not start at minimum speed");
  chk_hard_stop: assert property (stop_taken |=> hold_still)
    else $error("immediate stop did not hold at once");
  chk_step_count: assert property (step_pulse && !$past(fullstep_mode) |->
    absolute_position == $past(absolute_position) + ($past(step_dir) ? 22'h000001 : 22'h3fffff))
    else $error("position not moved by one step");
  chk_res_reset: assert property (cfg_write && cmd_ready && sel_new != sel_q |=>
    electrical_position == 6'h00 && !position_valid) else $error("resolution change missed");
  chk_osc_period: assert property (cmd_ready && seen_q && osc_chg |->
    osc_cnt_q == 5'd24) else $error("oscillator pin period wrong");
endmodule

bind stepper_motion_profile_core motion_core_checker chk (
  .mclk, .rst, .cfg_write, .min_speed, .step_sel, .cmd_valid, .cmd_code, .cmd_ready,
  .undervoltage_lockout_bit, .absolute_position, .position_valid, .current_speed,
  .motor_state, .bridges_enable, .fullstep_mode, .electrical_position, .step_pulse,
  .step_dir, .busy_oe_n, .flag_oe_n, .oscillator_output_pin
);

// ---- verif/host_model.sv ----
// Purpose: Host controller model issuing commands and configuration
// Assumes: Requests change 1 ns after the rising edge of mclk
// Notes:   Released command fields show the inverse of the last value
`timescale 1ns/10ps

module host_model (
  // Clock and device status
  input  wire logic        mclk,
  input  wire logic        bridges_enable,
  // Command port
  output logic             cmd_valid,
  output logic [3:0]       cmd_code,
  output logic             cmd_dir,
  output logic [19:0]      cmd_speed,
  output logic [21:0]      cmd_position,
  // Configuration
  output logic             cfg_write,
  output logic [11:0]      accel_rate,
  output logic [11:0]      decel_rate,
  output logic [9:0]       max_speed,
  output logic [11:0]      min_speed,
  output logic [9:0]       fullstep_threshold_speed,
  output logic [2:0]       step_sel
);
  // Quiet port at time zero
  initial begin
    {cmd_valid, cmd_code, cmd_dir, cmd_speed, cmd_position} = '0;
    {cfg_write, accel_rate, decel_rate, max_speed, min_speed} = '0;
    {fullstep_threshold_speed, step_sel} = '0;
  end

  // One command word, held for one taking edge
  task automatic send(input logic [3:0] c, input logic d, input logic [19:0] s,
                      input logic [21:0] p);
    @(posedge mclk);
    #1;
    {cmd_valid, cmd_code, cmd_dir, cmd_speed, cmd_position} = {1'b1, c, d, s, p};
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    {cmd_code, cmd_dir, cmd_speed, cmd_position} = ~{c, d, s, p};
  endtask

  // All limits written together, bridges released first
  task automatic write_cfg(input logic [11:0] a, input logic [11:0] dc, input logic [9:0] mx,
                           input logic [11:0] mn, input logic [9:0] fs, input logic [2:0] sel);
    if (bridges_enable) send(4'h8, 1'b0, 20'h0, 22'h0);
    @(posedge mclk);
    #1;
    cfg_write = 1'b1;
    {accel_rate, decel_rate, max_speed, min_speed} = {a, dc, mx, mn};
    {fullstep_threshold_speed, step_sel} = {fs, sel};
    @(posedge mclk);
    #1;
    cfg_write = 1'b0;
  endtask
endmodule

// ---- verif/stepper_motion_profile_core_test.sv ----
// Purpose: Self-checking bench of the stepper motion core
// Assumes: Host model drives requests 1 ns after the clock edge
// Notes:   Infinite acceleration keeps every move short
`timescale 1ns/10ps

module stepper_motion_profile_core_test;
  // Clock, pins and bench state
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        supply_ok, osc_ok, motor_supply_ok, status_clear;
  logic        cmd_valid, cmd_dir, cfg_write, cmd_ready, undervoltage_lockout_bit;
  logic [3:0]  cmd_code;
  logic [19:0] cmd_speed, sp;
  logic [21:0] cmd_position, absolute_position, p0;
  logic [11:0] accel_rate, decel_rate, min_speed, mn;
  logic [9:0]  max_speed, fullstep_threshold_speed, mx;
  logic [2:0]  step_sel, motor_state;
  logic [31:0] current_speed;
  logic [5:0]  electrical_position;
  logic        position_valid, bridges_enable, fullstep_mode, step_pulse, step_dir;
  logic        busy_o, busy_oe_n, flag_o, flag_oe_n, oscillator_output_pin;
  int          err_count = 0;
  int          n_compared = 0;
  int          seed = 59713;
  int          r, n, k, steps;

  always #5 mclk = ~mclk;

  stepper_motion_profile_core dut (
    .mclk, .rst, .supply_ok, .osc_ok, .motor_supply_ok, .cfg_write, .accel_rate,
    .decel_rate, .max_speed, .min_speed, .fullstep_threshold_speed, .step_sel,
    .cmd_valid, .cmd_code, .cmd_dir, .cmd_speed, .cmd_position, .cmd_ready, .status_clear,
    .undervoltage_lockout_bit, .absolute_position, .position_valid, .current_speed,
    .motor_state, .bridges_enable, .fullstep_mode, .electrical_position, .step_pulse,
    .step_dir, .busy_o, .busy_oe_n, .flag_o, .flag_oe_n, .oscillator_output_pin
  );
  host_model host (
    .mclk, .bridges_enable, .cmd_valid, .cmd_code, .cmd_dir, .cmd_speed, .cmd_position,
    .cfg_write, .accel_rate, .decel_rate, .max_speed, .min_speed,
    .fullstep_threshold_speed, .step_sel
  );

  // Speed held one tick after a run command
  function automatic logic [31:0] exp_run(input logic [19:0] s, input logic [9:0] m);
    return ({s, 12'h0} < {m, 22'h0}) ? {s, 12'h0} : {m, 22'h0};
  endfunction
  function automatic logic [21:0] exp_pos(input logic [21:0] p, input int d, input logic f);
    return f ? p + 22'(d) : p - 22'(d);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    $display("mismatch at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  // Bounded wait for a motion state, counting steps meanwhile
  task automatic run_until(input logic [2:0] s, input int lim);
    steps = 0;
    for (int i = 0; i < lim && motor_state !== s; i++) begin
      idle(1);
      if (step_pulse === 1'b1) steps++;
    end
    if (motor_state !== s) give_up();
  endtask

  initial begin
    {supply_ok, osc_ok, motor_supply_ok, status_clear} = 4'h0;
    idle(16);
    rst = 1'b0;
    check(cmd_ready, 1'b0);
    check(oscillator_output_pin, 1'b0);
    {supply_ok, osc_ok} = 2'h3;
    for (k = 0; k < 6 && cmd_ready !== 1'b1; k++) idle(1);
    if (cmd_ready !== 1'b1) give_up();
    check(undervoltage_lockout_bit, 1'b0);
    check(flag_oe_n, 1'b0);
    check(bridges_enable, 1'b0);
    // Motion refused while the motor supply is low
    host.send(4'h1, 1'b1, 20'hfffff, 22'h0);
    check(motor_state, 3'h0);
    motor_supply_ok = 1'b1;
    idle(2);
    check(undervoltage_lockout_bit, 1'b0);
    status_clear = 1'b1;
    idle(1);
    status_clear = 1'b0;
    check(flag_oe_n, 1'b1);
    check(undervoltage_lockout_bit, 1'b1);
    // Stop from high impedance, then a run on defaults
    host.send(4'h6, 1'b0, 20'h0, 22'h0);
    check(bridges_enable, 1'b1);
    check(current_speed, 32'h0);
    host.send(4'h1, 1'b1, 20'h00001, 22'h0);
    check(current_speed, 32'h0);
    check(busy_oe_n, 1'b0);
    // Idle and unknown codes leave the motion alone
    for (k = 0; k < 16; k = (k == 0) ? 9 : k + 1) begin
      host.send(4'(k), 1'b0, 20'h0, 22'h0);
      check(motor_state, 3'h2);
    end
    // Random limits: run, rerun, move, target, stop
    for (r = 0; r < 3; r++) begin
      mn = 12'($random(seed));
      mx = 10'h3c0 | 10'($random(seed));
      sp = 20'($random(seed));
      host.write_cfg(12'hfff, 12'hfff, mx, mn, 10'h3ff, 3'h4);
      host.send(4'h1, 1'b1, sp, 22'h0);
      check(current_speed, {4'h0, mn, 16'h0});
      idle(30);
      check(current_speed, exp_run(sp, mx));
      host.send(4'h1, 1'b0, ~sp, 22'h0);
      check(motor_state, 3'h2);
      n = 1 + ($random(seed) & 15);
      host.send(4'h6, 1'b0, 20'h0, 22'h0);
      p0 = absolute_position;
      host.send(4'h4, r[0], 20'h0, 22'(n));
      run_until(3'h1, n * 500 + 1000);
      check(steps, n);
      check(step_dir, r[0]);
      check(absolute_position, exp_pos(p0, n, r[0]));
      check(current_speed, 32'h0);
      k = 1 + ($random(seed) & 7);
      p0 = absolute_position;
      host.send(4'h2, 1'b0, 20'h0, exp_pos(p0, k, 1'b1));
      run_until(3'h1, k * 500 + 1000);
      check(absolute_position, exp_pos(p0, k, 1'b1));
      host.send(4'h3, 1'b0, 20'h0, p0);
      run_until(3'h1, k * 500 + 1000);
      check(steps, k);
      host.send(4'h1, 1'b1, sp, 22'h0);
      host.send(4'h5, 1'b0, 20'h0, 22'h0);
      run_until(3'h1, 300);
      check(bridges_enable, 1'b1);
    end
    host.send(4'h7, 1'b0, 20'h0, 22'h0);
    run_until(3'h0, 300);
    check(bridges_enable, 1'b0);
    // Quarter steps after a resolution change
    host.write_cfg(12'hfff, 12'hfff, 10'h3ff, 12'h0, 10'h3ff, 3'h2);
    check(electrical_position, 6'h00);
    check(position_valid, 1'b0);
    host.send(4'h4, 1'b1, 20'h0, 22'h1);
    run_until(3'h1, 3000);
    check(electrical_position, 6'h04);
    // Full steps above the threshold, microsteps again at rest
    host.write_cfg(12'hfff, 12'hfff, 10'h3ff, 12'h0, 10'h000, 3'h2);
    host.send(4'h1, 1'b1, 20'hfffff, 22'h0);
    idle(30);
    check(fullstep_mode, 1'b1);
    host.send(4'h6, 1'b0, 20'h0, 22'h0);
    idle(30);
    check(fullstep_mode, 1'b0);
    check({busy_o, flag_o}, 2'h0);
    tally_and_finish();
  end
endmodule
